// *** include/cache_ctl_consts.svh ***
// constants for the off-chip cache SRAM controller
// assumes: included by bare name from package and design files
`ifndef CACHE_CTL_CONSTS_SVH
`define CACHE_CTL_CONSTS_SVH

`define CC_INDEX_W 20
`define CC_SIZE_BASE 16
`define CC_LANES 8
`define CC_LANE_W 16
`define CC_TAG_W 20
`define CC_QPTR_W 3
`define CC_QDEPTH 4
`define CC_WR_RD_BIAS 4'h1
`define CC_WR_RD_BIAS_SD2 4'h2
`define CC_RATIO_X2_TWO 4'h4
`define CC_RD_WR_BIAS 8'h06
`define CC_RD_WR_ZERO 8'h40
`define CC_LAST_BEAT 2'h3
`define CC_IDLE_MAX 8'hFF

`endif

// *** include/cache_pkg.sv ***
// types shared by the off-chip cache SRAM controller
// assumes: cache_ctl_consts.svh on the include path
`include "cache_ctl_consts.svh"

package cache_pkg;

    // static configuration, sampled between transactions
    typedef struct packed {
        logic [3:0] write_to_read_gap;
        logic [5:0] read_to_write_gap;
        logic cache_enable_bit;
        logic [3:0] cache_size_field;
        logic banking_enable;
        logic alternate_strobe_style;
        logic burst_strobe_style;
        logic read_read_gap_bit;
        logic write_write_gap_bit;
        logic bank_switch_gap_bit;
        logic dual_data_mode;
        logic [3:0] ratio_x2;
    } cfg_type;

    // control strobes toward the SRAMs, all active low
    typedef struct packed {
        logic address_load_strobe_n;
        logic data_output_enable_n;
        logic data_write_strobe_n;
        logic tag_output_enable_n;
        logic tag_write_strobe_n;
    } strobe_type;

    typedef enum logic {ST_IDLE, ST_BEAT} st_type;

endpackage

// *** hdl/cache_return_sync.sv ***
// forwarded-clock receive queue: captures one word per rising return clock edge
// assumes: return clock runs only during returning beats; core drains
// one word per core cycle, no back-pressure toward the SRAMs
`timescale 1ns/100ps
`default_nettype none
`include "cache_ctl_consts.svh"

module cache_return_sync #(
    parameter int WIDTH = 16
) (
    // core side
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic [WIDTH-1:0] word_o,
    output logic word_valid_o,
    // link side
    input wire logic link_clk_i,
    input wire logic [WIDTH-1:0] link_data_i
);

    // ========================================
    // link domain: write side
    logic [WIDTH-1:0] mem_r [`CC_QDEPTH];
    logic [`CC_QPTR_W-1:0] wbin_r;
    logic [`CC_QPTR_W-1:0] wgray_r;
    wire [`CC_QPTR_W-1:0] wbin_nxt = wbin_r + `CC_QPTR_W'(1);

    always_ff @(posedge link_clk_i) begin
        mem_r[wbin_r[1:0]] <= link_data_i;
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wbin_r <= '0;
            wgray_r <= '0;
        end else begin
            wbin_r <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
        end
    end

    // ========================================
    // core domain: gray pointer crossing and drain
    logic [`CC_QPTR_W-1:0] wsync1_r;
    logic [`CC_QPTR_W-1:0] wsync2_r;
    logic [`CC_QPTR_W-1:0] rbin_r;
    wire [`CC_QPTR_W-1:0] rgray = rbin_r ^ (rbin_r >> 1);
    wire not_empty = (rgray != wsync2_r);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wsync1_r <= '0;
            wsync2_r <= '0;
            rbin_r <= '0;
            word_o <= '0;
            word_valid_o <= 1'b0;
        end else begin
            wsync1_r <= wgray_r;
            wsync2_r <= wsync1_r;
            word_valid_o <= not_empty;
            if (not_empty) begin
                word_o <= mem_r[rbin_r[1:0]];
                rbin_r <= rbin_r + `CC_QPTR_W'(1);
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/offchip_cache_sram_control.sv ***
// off-chip cache SRAM controller: gaps, index pins, strobes, return path
// assumes: configuration and requests come from core-clock logic;
// returned data and tag arrive on forwarded clocks from the SRAMs
// Contract
// - write-to-read spacing is (write_to_read_gap - 1) times frame ratio
// - single-data at ratio two: spacing is (gap - 2) times frame ratio
// - read_to_write_gap of zero means 64 core cycles
// - with cache enabled, size codes 0,1,3,7,F select 1 to 16MB
// - without banking, index pins above the cache size stay zero
// - with banking, next higher index pin carries inverted top index bit
// - strobe style: 00 type A, burst alone type B, alternate unsupported
// - type A strobe pattern per read and write beat
// - type B: load pulses on first beat, data write low outside reads
// - output enables act as chip selects in types A and B
// - eight data clocks and one tag clock, resynchronised to core clock
// - read-read gap bit adds one cache cycle between reads
// - write-write gap bit adds one cache cycle between writes
// - bank-switch gap bit adds one cache cycle between cross-bank reads
// - frame ratio: twice ratio dual-data; single-data ratio if even
`timescale 1ns/100ps
`default_nettype none
`include "cache_ctl_consts.svh"

module offchip_cache_sram_control (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire cache_pkg::cfg_type cfg_i,
    // request from the core
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`CC_INDEX_W-1:0] req_index_i,
    output logic req_taken_o,
    output logic busy_o,
    output logic cfg_error_o,
    // SRAM address and control
    output logic [`CC_INDEX_W-1:0] cache_index_pins_o,
    output cache_pkg::strobe_type strobes_o,
    // return path
    input wire logic [`CC_LANES-1:0] data_return_clocks_i,
    input wire logic tag_return_clock_i,
    input wire logic [`CC_LANES*`CC_LANE_W-1:0] data_in_i,
    input wire logic [`CC_TAG_W-1:0] tag_in_i,
    output logic [`CC_LANES*`CC_LANE_W-1:0] data_out_o,
    output logic [`CC_LANES-1:0] data_lane_valid_o,
    output logic [`CC_TAG_W-1:0] tag_out_o,
    output logic tag_valid_o
);
    import cache_pkg::*;

    // ========================================
    // strobe decode
    function automatic strobe_type strobe_decode(input logic active,
            input logic [1:0] beat, input logic wr, input logic type_b);
        strobe_type s;
        logic first;
        first = active && (beat == 2'h0);
        s.address_load_strobe_n = type_b ? ~first : 1'b1;
        s.data_output_enable_n = ~active;
        s.data_write_strobe_n = type_b ? (active & ~wr) : ~(active & wr);
        s.tag_output_enable_n = ~first;
        s.tag_write_strobe_n = ~(first & wr);
        return s;
    endfunction

    // ========================================
    // state
    st_type state_r, state_nxt;
    cfg_type cfg_r;
    logic [1:0] beat_r, beat_nxt;
    logic [3:0] cyc_r, cyc_nxt;
    logic [7:0] idle_r;
    logic cur_write_r, cur_bank_r;
    logic last_write_r, last_bank_r, have_last_r;
    strobe_type strb_nxt;

    // ========================================
    // frame ratio and gap arithmetic
    wire sd_even = !cfg_r.dual_data_mode && (cfg_r.ratio_x2[1:0] == 2'h0);
    wire [3:0] bcfrm = sd_even ? (cfg_r.ratio_x2 >> 1) : cfg_r.ratio_x2;
    wire sd_two = !cfg_r.dual_data_mode &&
                  (cfg_r.ratio_x2 == `CC_RATIO_X2_TWO);
    wire [3:0] wr_rd_bias = sd_two ? `CC_WR_RD_BIAS_SD2 : `CC_WR_RD_BIAS;
    wire [3:0] wr_rd_mult = (cfg_r.write_to_read_gap > wr_rd_bias) ?
                            4'(cfg_r.write_to_read_gap - wr_rd_bias) : 4'h0;
    wire [7:0] wr_rd_need = 8'(wr_rd_mult) * 8'(bcfrm);
    wire [7:0] rd_wr_need = (cfg_r.read_to_write_gap == 6'h00) ?
        `CC_RD_WR_ZERO : (8'(cfg_r.read_to_write_gap) + `CC_RD_WR_BIAS);
    wire [3:0] ccyc_raw = 4'((5'(cfg_r.ratio_x2) + 5'h01) >> 1);
    wire [3:0] ccyc = (ccyc_raw == 4'h0) ? 4'h1 : ccyc_raw;

    // ========================================
    // index mapping, banking and bank of request
    wire [4:0] used_ext = {cfg_r.cache_size_field, 1'b1};
    wire [4:0] used_hi = {1'b0, cfg_r.cache_size_field};
    wire [`CC_INDEX_W-1:0] idx_map;
    wire [4:0] bank_terms;
    wire req_bank = |bank_terms;

    assign idx_map[`CC_SIZE_BASE-1:0] = req_index_i[`CC_SIZE_BASE-1:0];
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_upper
            wire bank_pin = cfg_r.banking_enable && used_ext[k] &&
                            !cfg_r.cache_size_field[k];
            assign idx_map[`CC_SIZE_BASE+k] =
                cfg_r.cache_size_field[k] ? req_index_i[`CC_SIZE_BASE+k] :
                (bank_pin ? ~req_index_i[`CC_SIZE_BASE+k-1] : 1'b0);
        end
        for (k = 0; k < 5; k++) begin : g_bank
            assign bank_terms[k] = used_ext[k] && !used_hi[k] &&
                                   req_index_i[`CC_SIZE_BASE+k-1];
        end
    endgenerate

    // ========================================
    // start decision
    wire rr_gap = cfg_r.read_read_gap_bit ||
                  (cfg_r.bank_switch_gap_bit && (req_bank != last_bank_r));
    wire [7:0] need =
        !have_last_r ? 8'h00 :
        (last_write_r && !req_write_i) ? wr_rd_need :
        (!last_write_r && req_write_i) ? rd_wr_need :
        (req_write_i ? (cfg_r.write_write_gap_bit ? 8'(ccyc) : 8'h00)
                     : (rr_gap ? 8'(ccyc) : 8'h00));
    wire style_ok = !cfg_r.alternate_strobe_style;
    wire start_ok = (8'(idle_r + 8'h01) >= need) || (idle_r == `CC_IDLE_MAX);
    wire take = (state_r == ST_IDLE) && req_valid_i && start_ok &&
                style_ok && cfg_r.cache_enable_bit;
    wire beat_end = (cyc_r == 4'(ccyc - 4'h1));
    wire last_end = (state_r == ST_BEAT) && beat_end &&
                    (beat_r == `CC_LAST_BEAT);

    always_comb begin
        state_nxt = state_r;
        beat_nxt = beat_r;
        cyc_nxt = cyc_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_BEAT;
                    beat_nxt = 2'h0;
                    cyc_nxt = 4'h0;
                end
            end
            ST_BEAT: begin
                cyc_nxt = beat_end ? 4'h0 : 4'(cyc_r + 4'h1);
                if (beat_end) begin
                    beat_nxt = 2'(beat_r + 2'h1);
                end
                if (last_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    wire nxt_write = take ? req_write_i : cur_write_r;
    assign strb_nxt = strobe_decode(state_nxt == ST_BEAT, beat_nxt, nxt_write,
                                    cfg_r.burst_strobe_style);

    // ========================================
    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            beat_r <= 2'h0;
            cyc_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            beat_r <= beat_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r <= '0;
        end else if (state_r == ST_IDLE && !take) begin
            cfg_r <= cfg_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_r <= 8'h00;
        end else if (state_r == ST_BEAT) begin
            idle_r <= 8'h00;
        end else if (idle_r != `CC_IDLE_MAX) begin
            idle_r <= 8'(idle_r + 8'h01);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_write_r <= 1'b0;
            cur_bank_r <= 1'b0;
            last_write_r <= 1'b0;
            last_bank_r <= 1'b0;
            have_last_r <= 1'b0;
        end else if (take) begin
            cur_write_r <= req_write_i;
            cur_bank_r <= req_bank;
        end else if (last_end) begin
            last_write_r <= cur_write_r;
            last_bank_r <= cur_bank_r;
            have_last_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobes_o <= '1;
            cache_index_pins_o <= '0;
            req_taken_o <= 1'b0;
            busy_o <= 1'b0;
            cfg_error_o <= 1'b0;
        end else begin
            strobes_o <= strb_nxt;
            if (take) begin
                cache_index_pins_o <= idx_map;
            end
            req_taken_o <= take;
            busy_o <= (state_nxt == ST_BEAT);
            cfg_error_o <= cfg_r.alternate_strobe_style;
        end
    end

    // ========================================
    // return path, one queue per forwarded clock
    generate
        for (k = 0; k < `CC_LANES; k++) begin : g_lane
            cache_return_sync #(.WIDTH(`CC_LANE_W)) u_lane (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .word_o(data_out_o[k*`CC_LANE_W +: `CC_LANE_W]),
                .word_valid_o(data_lane_valid_o[k]),
                .link_clk_i(data_return_clocks_i[k]),
                .link_data_i(data_in_i[k*`CC_LANE_W +: `CC_LANE_W])
            );
        end
    endgenerate

    cache_return_sync #(.WIDTH(`CC_TAG_W)) u_tag (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .word_o(tag_out_o),
        .word_valid_o(tag_valid_o),
        .link_clk_i(tag_return_clock_i),
        .link_data_i(tag_in_i)
    );

    // ========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [7:0] pin_idle_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_idle_r <= 8'h00;
        end else if (!strobes_o.data_output_enable_n) begin
            pin_idle_r <= 8'h00;
        end else if (pin_idle_r != `CC_IDLE_MAX) begin
            pin_idle_r <= 8'(pin_idle_r + 8'h01);
        end
    end
    // previous pin level, idle high so no false start after reset
    logic doe_n_q_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            doe_n_q_r <= 1'b1;
        end else begin
            doe_n_q_r <= strobes_o.data_output_enable_n;
        end
    end
    wire burst_start = doe_n_q_r && !strobes_o.data_output_enable_n;

    a_wr_rd_gap: assert property (burst_start && have_last_r && last_write_r
        && !cur_write_r && !sd_two |-> pin_idle_r >= wr_rd_need)
        else $error("write to read spacing too short");
    a_wr_rd_sd2: assert property (burst_start && have_last_r && last_write_r
        && !cur_write_r && sd_two |-> pin_idle_r >= wr_rd_need)
        else $error("single-data ratio two spacing too short");
    a_rd_wr_gap: assert property (burst_start && have_last_r && !last_write_r
        && cur_write_r |-> pin_idle_r >= rd_wr_need)
        else $error("read to write spacing too short");
    a_rr_bubble: assert property (burst_start && have_last_r && !last_write_r
        && !cur_write_r && cfg_r.read_read_gap_bit
        |-> pin_idle_r >= 8'(ccyc))
        else $error("read read bubble missing");
    a_ww_bubble: assert property (burst_start && have_last_r && last_write_r
        && cur_write_r && cfg_r.write_write_gap_bit
        |-> pin_idle_r >= 8'(ccyc))
        else $error("write write bubble missing");
    a_bank_switch: assert property (burst_start && have_last_r
        && !last_write_r && !cur_write_r && cfg_r.bank_switch_gap_bit
        && cur_bank_r != last_bank_r |-> pin_idle_r >= 8'(ccyc))
        else $error("bank switch bubble missing");
    a_index_zero: assert property (burst_start && !cfg_r.banking_enable
        |-> (cache_index_pins_o[`CC_INDEX_W-1:`CC_SIZE_BASE]
             & ~cfg_r.cache_size_field) == 4'h0)
        else $error("index pin above cache size not zero");
    a_type_a_load: assert property (state_r == ST_BEAT
        && !cfg_r.burst_strobe_style |=> strobes_o.address_load_strobe_n)
        else $error("type A load strobe went low");
    a_type_b_first: assert property (burst_start && cfg_r.burst_strobe_style
        |-> !strobes_o.address_load_strobe_n
            ##1 (ccyc != 4'h1 || strobes_o.address_load_strobe_n))
        else $error("type B load strobe not one beat");
    a_tag_first: assert property (burst_start |-> !strobes_o.tag_output_enable_n
        && (strobes_o.tag_write_strobe_n == !cur_write_r))
        else $error("tag strobe not on first beat");
    a_cfg_static: assert property (state_r == ST_BEAT |=> $stable(cfg_r))
        else $error("configuration changed inside transaction");
    a_burst_len: assert property (req_taken_o |-> busy_o
        ##1 busy_o[*3])
        else $error("burst shorter than four beats");

    c_read: cover property (burst_start && !cur_write_r);
    c_write: cover property (burst_start && cur_write_r);
    c_wr_then_rd: cover property (burst_start && last_write_r
        && !cur_write_r && have_last_r);
    c_bank_sw: cover property (burst_start && cur_bank_r != last_bank_r);

endmodule
`default_nettype wire

// *** dv/cache_sram_model.sv ***
// synchronous SRAM pair model: answers each read burst on forwarded clocks
// assumes: read start seen as chip selects low with write strobe high
`timescale 1ns/100ps
`default_nettype none

module cache_sram_model (
    // core side view of the pins
    input wire logic clk_i,
    input wire cache_pkg::strobe_type strobes_i,
    input wire logic [19:0] index_i,
    // return path
    output logic [7:0] data_clk_o,
    output logic tag_clk_o,
    output logic [127:0] data_o,
    output logic [19:0] tag_o
);
    import cache_pkg::*;
    logic doe_q = 1'b1;
    logic [19:0] idx = 20'h00000;
    event start_ev;

    initial begin
        data_clk_o = 8'h00;
        tag_clk_o = 1'b0;
        data_o = {8{16'hA5C3}};
        tag_o = 20'h5A3C5;
    end

    // first read beat: chip selects drop while write strobe stays high
    always @(posedge clk_i) begin
        if (!strobes_i.data_output_enable_n && doe_q && strobes_i.data_write_strobe_n) begin
            idx = index_i;
            -> start_ev;
        end
        doe_q = strobes_i.data_output_enable_n;
    end

    // clocks stand still between frames; released lines show inverted data
    initial forever begin
        @(start_ev);
        #3;
        for (int b = 0; b < 4; b++) begin
            for (int k = 0; k < 8; k++) data_o[16*k +: 16] = {idx[10:0], 3'(k), 2'(b)};
            if (b == 0) tag_o = idx;
            #3;
            data_clk_o = 8'hFF;
            tag_clk_o = (b == 0);
            #6;
            data_clk_o = 8'h00;
            tag_clk_o = 1'b0;
            data_o = ~data_o;
            tag_o = ~tag_o;
            #3;
        end
    end
endmodule
`default_nettype wire

// *** dv/offchip_cache_sram_control_bench.sv ***
// testbench: random bursts over a table of settings, refusals, return data
// assumes: package, design and sram model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "cache_ctl_consts.svh"

module offchip_cache_sram_control_bench;
    import cache_pkg::*;
    typedef struct packed {
        logic [7:0] gap;
        logic [19:0] pins;
        logic [4:0] s0;
        logic [4:0] s1;
        logic [4:0] sidle;
    } note_type;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cfg_type cfg = '0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [19:0] req_index = 20'h00000;
    logic taken, busy, cfg_err, tag_valid, tag_clk;
    logic [19:0] pins, tag_out, tag_in;
    strobe_type strobes;
    logic [7:0] lane_valid, data_clks;
    logic [127:0] data_out, data_in;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 92428;
    int idle_cnt = 0;
    int beat_t = -1;
    logic prev_wr = 1'b0;
    logic prev_bank = 1'b0;
    logic [3:0] rt[4] = '{4'h4, 4'h2, 4'h5, 4'h3};
    note_type cur;
    note_type notes[$];
    logic [15:0] dq[8][$];
    logic [19:0] tq[$];

    always #20 clk = ~clk;

    offchip_cache_sram_control u_offchip_cache_sram_control (
        .clk_i(clk), .rst_n_i(rst_n), .cfg_i(cfg),
        .req_valid_i(req_valid), .req_write_i(req_write),
        .req_index_i(req_index), .req_taken_o(taken), .busy_o(busy),
        .cfg_error_o(cfg_err), .cache_index_pins_o(pins),
        .strobes_o(strobes), .data_return_clocks_i(data_clks),
        .tag_return_clock_i(tag_clk), .data_in_i(data_in),
        .tag_in_i(tag_in), .data_out_o(data_out),
        .data_lane_valid_o(lane_valid), .tag_out_o(tag_out),
        .tag_valid_o(tag_valid));

    cache_sram_model u_cache_sram_model (
        .clk_i(clk), .strobes_i(strobes), .index_i(pins),
        .data_clk_o(data_clks), .tag_clk_o(tag_clk),
        .data_o(data_in), .tag_o(tag_in));

    // ========================================
    // checking helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // load, data oe, data wr, tag oe, tag wr
    function automatic logic [4:0] stb(input logic wr, input logic f, input logic tb);
        stb = {~(tb & f), 1'b0, ~wr, ~f, ~(wr & f)};
    endfunction

    function automatic int need(input logic wr, input logic bdiff);
        int bf, cc, n;
        cc = (cfg.ratio_x2 + 1) / 2;
        bf = (!cfg.dual_data_mode && cfg.ratio_x2 % 4 == 0) ? cfg.ratio_x2 / 2 : cfg.ratio_x2;
        if (prev_wr && !wr) n = (cfg.write_to_read_gap - ((!cfg.dual_data_mode && cfg.ratio_x2 == 4) ? 2 : 1)) * bf;
        else if (!prev_wr && wr) n = (cfg.read_to_write_gap == 0) ? 64 : cfg.read_to_write_gap + 6;
        else if (wr) n = cfg.write_write_gap_bit ? cc : 0;
        else n = (cfg.read_read_gap_bit || (cfg.bank_switch_gap_bit && bdiff)) ? cc : 0;
        need = (n < 1) ? 1 : n;
    endfunction

    // ========================================
    // driver: notes expectations, then requests
    task automatic do_op(input logic wr, input logic first);
        int w, k;
        logic [19:0] ix, ex;
        note_type nt;
        w = `CC_SIZE_BASE + $countones(cfg.cache_size_field);
        ix = 20'($random(seed));
        ex = ix & ((20'h1 << w) - 20'h1);
        if (cfg.banking_enable && w < 20) ex[w] = ~ix[w-1];
        nt.gap = first ? 8'hFF : 8'(need(wr, ix[w-1] != prev_bank));
        nt.pins = ex;
        nt.s0 = stb(wr, 1'b1, cfg.burst_strobe_style);
        nt.s1 = stb(wr, 1'b0, cfg.burst_strobe_style);
        nt.sidle = {2'b11, ~cfg.burst_strobe_style, 2'b11};
        notes.push_back(nt);
        if (!wr) begin
            for (k = 0; k < 32; k++) dq[k%8].push_back({ex[10:0], 3'(k % 8), 2'(k / 8)});
            tq.push_back(ex);
        end
        req_index = ix;
        req_write = wr;
        req_valid = 1'b1;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (!taken && k < 200);
        if (k >= 200) chk(32'h0, 32'h1);
        req_valid = 1'b0;
        prev_wr = wr;
        prev_bank = ix[w-1];
        @(negedge clk);
    endtask

    // ========================================
    // monitors: bursts at the pins, returned words
    always @(negedge clk) begin
        if (taken) begin
            if (notes.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                cur = notes.pop_front();
                if (cur.gap != 8'hFF) chk(idle_cnt, cur.gap);
                chk(pins, cur.pins);
                chk(strobes, cur.s0);
                beat_t = 0;
            end
        end else if (beat_t >= 0) begin
            beat_t++;
        end
        if (beat_t == (cfg.ratio_x2 + 1) / 2) begin
            chk(strobes, cur.s1);
            chk(busy, 1);
        end
        if (beat_t == 4 * ((cfg.ratio_x2 + 1) / 2)) begin
            chk(strobes, cur.sidle);
            chk(busy, 0);
            beat_t = -1;
        end
        idle_cnt = strobes.data_output_enable_n ? idle_cnt + 1 : 0;
        for (int k = 0; k < 8; k++) begin
            if (lane_valid[k] && dq[k].size() == 0) chk(32'h1, 32'h0);
            else if (lane_valid[k]) chk(data_out[16*k +: 16], dq[k].pop_front());
        end
        if (tag_valid && tq.size() == 0) chk(32'h1, 32'h0);
        else if (tag_valid) chk(tag_out, tq.pop_front());
    end

    // ========================================
    // main sequence
    initial begin
        int i, j;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++) begin
            cfg.write_to_read_gap = 4'(2 + i % 5);
            cfg.read_to_write_gap = (i == 3) ? 6'h00 : 6'(i * 5 + 1);
            cfg.cache_enable_bit = 1'b1;
            cfg.cache_size_field = 4'((5'h01 << (i % 5)) - 5'h01);
            cfg.banking_enable = i[1];
            cfg.alternate_strobe_style = 1'b0;
            cfg.burst_strobe_style = i[0];
            cfg.dual_data_mode = i[2];
            cfg.ratio_x2 = rt[i%4];
            {cfg.read_read_gap_bit, cfg.write_write_gap_bit, cfg.bank_switch_gap_bit} = 3'($random(seed));
            repeat (3) @(negedge clk);
            for (j = 0; j < 12; j++) do_op(1'($random(seed)), j == 0);
            repeat (90) @(negedge clk);
        end
        cfg.alternate_strobe_style = 1'b1;
        repeat (3) @(negedge clk);
        chk(cfg_err, 1);
        req_valid = 1'b1;
        repeat (20) @(negedge clk);
        req_valid = 1'b0;
        cfg.alternate_strobe_style = 1'b0;
        cfg.cache_enable_bit = 1'b0;
        repeat (3) @(negedge clk);
        chk(cfg_err, 0);
        req_valid = 1'b1;
        repeat (20) @(negedge clk);
        req_valid = 1'b0;
        cfg.cache_enable_bit = 1'b1;
        repeat (3) @(negedge clk);
        do_op(1'b0, 1'b1);
        repeat (40) @(negedge clk);
        chk(notes.size() + tq.size() + dq[0].size() + dq[7].size(), 0);
        results();
    end

    initial begin
        #800000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
